// ---- pprr_pkg.sv ----
// Shared constants for the row repair model: commands, register fields,
// timing counts at the 10 MHz command clock.
// Assumes a single clock domain shared by both ends.
package pprr_pkg;
  localparam int unsigned CLK_MHZ          = 10;
  localparam int unsigned CLK_PERIOD_NS    = 100;
  // Fuse programming time in ms, latch time in ns, settle time in us
  localparam int unsigned FUSE_PGM_MS      = 1000;
  localparam int unsigned LATCH_NS         = 15;
  localparam int unsigned SETTLE_US        = 50;
  localparam int unsigned MODE_WR_NS       = 200;
  localparam int unsigned FUSE_PGM_CYC     = FUSE_PGM_MS * 1000 * CLK_MHZ;
  localparam int unsigned LATCH_CYC        =
    (LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC       = SETTLE_US * CLK_MHZ;
  localparam int unsigned MODE_WR_CYC      =
    (MODE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Mode register addresses and fields
  localparam logic [7:0] REFRESH_REPAIR_MODE_REG = 8'h04;
  localparam logic [7:0] REPAIR_AVAILABILITY_REG = 8'h19;
  localparam int unsigned REPAIR_ENABLE_BIT      = 4;
  localparam logic [7:0] REPAIR_AVAIL_RESET      = 8'h00;
  localparam logic [7:0] REFRESH_REPAIR_RESET    = 8'h00;
  localparam int unsigned BANKS      = 8;
  localparam int unsigned BANK_W     = 3;
  localparam int unsigned ROW_W      = 14;
  localparam int unsigned CNT_W      = 32;
  typedef enum logic [2:0] {
    PPRR_CMD_NOP = 3'h0,
    PPRR_CMD_ACT = 3'h1,
    PPRR_CMD_PRE = 3'h2,
    PPRR_CMD_MRW = 3'h3,
    PPRR_CMD_MRR = 3'h4,
    PPRR_CMD_REF = 3'h5
  } pprr_cmd_type;
endpackage

// ---- pprr_if.sv ----
// Command link between memory controller and memory die.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pprr_if;
  import pprr_pkg::*;
  pprr_cmd_type      cmd;
  logic              cmd_valid;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0]  row;
  logic [7:0]        mr_addr;
  logic [7:0]        mr_data;
  logic [7:0]        rd_data;
  logic              rd_valid;
  logic              ready;
  modport ctrl (output cmd, cmd_valid, bank, row, mr_addr, mr_data,
                input rd_data, rd_valid, ready);
  modport die  (input cmd, cmd_valid, bank, row, mr_addr, mr_data,
                output rd_data, rd_valid, ready);
endinterface
`default_nettype wire

// ---- pprr_die.sv ----
// Memory die end of the row repair link: mode registers, repair fuses.
// Assumes the controller keeps its own ordering and waiting obligations.
// Misordered commands are not refused; extra activates and commands offered while fusing raise
// a sticky error flag, so whoever drives the link can see that it broke the order.
// Fuse bits only ever set; arst_n stands in for power-up and clears them.
// Ready is combinational from the state register alone.
//
// Contract
// - Availability readable as 8-bit read-only register
// - At most one repaired row per bank
// - Programmed fuse never returns to unprogrammed
// - Controller guards against accidental repair entry
// - Controller precharges all banks before enable; here it only starts when banks_idle is high
// - Controller sets enable bit, waits mode delay
// - Controller activates failing row in repair mode
// - Activate then at least programming time wait
// - No commands during programming interval
// - Precharge then at least 15 ns latch
// - Controller clears enable bit to exit
// - Commands accepted only after 50 us settle
// - Controller repeats sequence per failing address
// - One row per die per sequence
// - Controller runs reset procedure afterwards; here it only raises need_reset
// - No refresh during repair, contents lost
// - Host may verify by write and read
`timescale 1ns/1ps
`default_nettype none
module pprr_die
  import pprr_pkg::*;
#(
  parameter logic [7:0]  AVAIL_CODE = 8'h01,  // Arbitrary capability code
  parameter int unsigned PGM_CYC    = FUSE_PGM_CYC,
  parameter int unsigned SETTLE     = SETTLE_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  pprr_if.die                    lnk,
  output logic [BANKS-1:0]       fuse_used,
  output logic [BANKS*ROW_W-1:0] fuse_rows,
  output logic                   repair_busy,
  output logic                   contents_lost,
  output logic                   repair_error
);
  typedef enum logic [2:0] {
    PPRR_IDLE   = 3'b000,
    PPRR_EN     = 3'b001,
    PPRR_PGM    = 3'b011,
    PPRR_WAITPR = 3'b010,
    PPRR_LATCH  = 3'b110,
    PPRR_DONE   = 3'b111,
    PPRR_SETTLE = 3'b101
  } pprr_st_type;

  typedef struct packed {
    pprr_st_type             st;
    logic [7:0]              mr4;
    logic [CNT_W-1:0]        cnt;
    logic [BANK_W-1:0]       tbank;
    logic [ROW_W-1:0]        trow;
    logic                    seq_used;
    logic [BANKS-1:0]        used;
    logic [BANKS*ROW_W-1:0]  rows;
    logic [7:0]              rd;
    logic                    rdv;
    logic                    lost;
    logic                    err;
  } pprr_die_type;

  pprr_die_type s_r, s_nxt;
  logic acc;

  // A command is taken when offered while ready
  assign acc = lnk.cmd_valid && lnk.ready;

  // Next state of mode registers and repair sequencer
  always_comb begin
    s_nxt     = s_r;
    s_nxt.rdv = 1'b0;
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    if (acc && lnk.cmd == PPRR_CMD_MRR) begin
      s_nxt.rdv = 1'b1;
      if (lnk.mr_addr == REPAIR_AVAILABILITY_REG) begin
        s_nxt.rd = AVAIL_CODE;
      end else if (lnk.mr_addr == REFRESH_REPAIR_MODE_REG) begin
        s_nxt.rd = s_r.mr4;
      end else begin
        s_nxt.rd = 8'h00;
      end
    end
    // Only the repair mode register takes writes
    if (acc && lnk.cmd == PPRR_CMD_MRW &&
        lnk.mr_addr == REFRESH_REPAIR_MODE_REG) begin
      s_nxt.mr4 = lnk.mr_data;
    end
    case (s_r.st)
      PPRR_IDLE: begin
        // activate outside repair mode programs nothing
        if (s_nxt.mr4[REPAIR_ENABLE_BIT]) begin
          s_nxt.st       = PPRR_EN;
          s_nxt.seq_used = 1'b0;
        end
      end
      PPRR_EN: begin
        // Exit before any activate goes straight to settle
        if (!s_nxt.mr4[REPAIR_ENABLE_BIT]) begin
          s_nxt.st  = PPRR_SETTLE;
          s_nxt.cnt = CNT_W'(SETTLE);
        end else if (acc && lnk.cmd == PPRR_CMD_ACT) begin
          if (s_r.seq_used) begin
            s_nxt.err = 1'b1;
          end else begin
            s_nxt.st       = PPRR_PGM;
            s_nxt.tbank    = lnk.bank;
            s_nxt.trow     = lnk.row;
            s_nxt.seq_used = 1'b1;
            s_nxt.lost     = 1'b1;
            s_nxt.cnt      = CNT_W'(PGM_CYC);
          end
        end
      end
      PPRR_PGM: begin
        if (s_r.cnt <= CNT_W'(1)) begin
          s_nxt.st = PPRR_WAITPR;
        end
        // any command other than NOP offered while fusing is an error
        if (lnk.cmd_valid && lnk.cmd != PPRR_CMD_NOP) begin
          s_nxt.err = 1'b1;
        end
      end
      PPRR_WAITPR: begin
        if (acc && lnk.cmd == PPRR_CMD_PRE) begin
          s_nxt.st  = PPRR_LATCH;
          s_nxt.cnt = CNT_W'(LATCH_CYC);
        // a second row in one sequence is taken but only raises the error flag
        end else if (acc && lnk.cmd == PPRR_CMD_ACT) begin
          s_nxt.err = 1'b1;
        end
      end
      PPRR_LATCH: begin
        if (s_r.cnt <= CNT_W'(1)) begin
          s_nxt.st = PPRR_DONE;
          // one row per bank; fuses only set
          if (s_r.used[s_r.tbank]) begin
            s_nxt.err = 1'b1;
          end else begin
            s_nxt.used[s_r.tbank] = 1'b1;
            s_nxt.rows[s_r.tbank*ROW_W +: ROW_W] = s_r.trow;
          end
        end
      end
      PPRR_DONE: begin
        if (!s_nxt.mr4[REPAIR_ENABLE_BIT]) begin
          s_nxt.st  = PPRR_SETTLE;
          s_nxt.cnt = CNT_W'(SETTLE);
        // used sequence: a further activate is taken but only raises the error flag
        end else if (acc && lnk.cmd == PPRR_CMD_ACT && s_r.seq_used) begin
          s_nxt.err = 1'b1;
        end
      end
      PPRR_SETTLE: begin
        // settle before commands
        // Offered commands wait here, ready stays low
        if (s_r.cnt <= CNT_W'(1)) begin
          s_nxt.st = PPRR_IDLE;
        end
      end
      default: s_nxt.st = PPRR_IDLE;
    endcase
  end

  // State register; fuses persist across everything but power-up reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: PPRR_IDLE, mr4: REFRESH_REPAIR_RESET, cnt: '0,
               tbank: '0, trow: '0, seq_used: 1'b0, used: '0,
               rows: '0, rd: 8'h00, rdv: 1'b0, lost: 1'b0, err: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.ready   = (s_r.st != PPRR_PGM) && (s_r.st != PPRR_LATCH) &&
                       (s_r.st != PPRR_SETTLE);

  // Read answer straight from its registers
  assign lnk.rd_data  = s_r.rd;
  assign lnk.rd_valid = s_r.rdv;

  // Per-bank fuse view, one slice per bank
  for (genvar g = 0; g < BANKS; g++) begin : g_fuse
    assign fuse_used[g]                = s_r.used[g];
    assign fuse_rows[g*ROW_W +: ROW_W] = s_r.rows[g*ROW_W +: ROW_W];
  end

  // Status flags
  assign repair_busy   = (s_r.st != PPRR_IDLE);
  assign contents_lost = s_r.lost;
  assign repair_error  = s_r.err;
endmodule
`default_nettype wire

// ---- pprr_ctrl.sv ----
// Controller end: runs one repair sequence per request.
// Assumes the die answers mode reads one cycle after acceptance.
`timescale 1ns/1ps
`default_nettype none
module pprr_ctrl
  import pprr_pkg::*;
#(
  parameter int unsigned PGM_CYC = FUSE_PGM_CYC,
  parameter int unsigned SETTLE  = SETTLE_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  pprr_if.ctrl                   lnk,
  input  wire logic              req,
  input  wire logic              arm,
  input  wire logic              banks_idle,
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic [ROW_W-1:0]  req_row,
  output logic                   busy,
  output logic                   done,
  output logic                   need_reset
);
  typedef enum logic [2:0] {
    PPRC_IDLE = 3'b000, PPRC_EN = 3'b001, PPRC_MRD = 3'b011,
    PPRC_ACT  = 3'b010, PPRC_PGM = 3'b110, PPRC_PRE = 3'b111,
    PPRC_LAT  = 3'b101, PPRC_EXIT = 3'b100
  } pprr_ctrl_st_type;

  typedef struct packed {
    pprr_ctrl_st_type  st;
    logic [CNT_W-1:0]  cnt;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic              done;
    logic              nrst;
  } pprr_ctrl_type;

  pprr_ctrl_type s_r, s_nxt;
  logic          fire;

  assign fire = lnk.cmd_valid && lnk.ready;

  // Sequencer next state
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    case (s_r.st)
      PPRC_IDLE: if (req && arm && banks_idle) begin
        s_nxt.st   = PPRC_EN;
        s_nxt.bank = req_bank;
        s_nxt.row  = req_row;
      end
      // set enable bit; held until die ready
      PPRC_EN: if (fire) begin
        s_nxt.st  = PPRC_MRD;
        s_nxt.cnt = CNT_W'(MODE_WR_CYC);
      end
      PPRC_MRD: if (s_r.cnt <= CNT_W'(1)) s_nxt.st = PPRC_ACT;
      PPRC_ACT: if (fire) begin
        s_nxt.st  = PPRC_PGM;
        s_nxt.cnt = CNT_W'(PGM_CYC);
      end
      PPRC_PGM: if (s_r.cnt <= CNT_W'(1)) s_nxt.st = PPRC_PRE;
      PPRC_PRE: if (fire) begin
        s_nxt.st  = PPRC_LAT;
        s_nxt.cnt = CNT_W'(LATCH_CYC);
      end
      PPRC_LAT: if (s_r.cnt <= CNT_W'(1)) s_nxt.st = PPRC_EXIT;
      PPRC_EXIT: if (fire) begin
        s_nxt.st   = PPRC_IDLE;
        s_nxt.done = 1'b1;
        s_nxt.nrst = 1'b1;
      end
      default: s_nxt.st = PPRC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: PPRC_IDLE, cnt: '0, bank: '0, row: '0,
               done: 1'b0, nrst: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Command drive per state
  always_comb begin
    lnk.cmd       = PPRR_CMD_NOP;
    lnk.cmd_valid = 1'b0;
    lnk.bank      = s_r.bank;
    lnk.row       = s_r.row;
    lnk.mr_addr   = REFRESH_REPAIR_MODE_REG;
    lnk.mr_data   = REFRESH_REPAIR_RESET;
    case (s_r.st)
      PPRC_EN: begin
        lnk.cmd       = PPRR_CMD_MRW;
        lnk.cmd_valid = 1'b1;
        lnk.mr_data   = 8'h01 << REPAIR_ENABLE_BIT;
      end
      PPRC_ACT: begin
        lnk.cmd       = PPRR_CMD_ACT;
        lnk.cmd_valid = 1'b1;
      end
      PPRC_PRE: begin
        lnk.cmd       = PPRR_CMD_PRE;
        lnk.cmd_valid = 1'b1;
      end
      PPRC_EXIT: begin
        lnk.cmd       = PPRR_CMD_MRW;
        lnk.cmd_valid = 1'b1;
      end
      default: lnk.cmd_valid = 1'b0;
    endcase
  end

  assign busy       = (s_r.st != PPRC_IDLE);
  assign done       = s_r.done;
  assign need_reset = s_r.nrst;
endmodule
`default_nettype wire

// ---- pprr_chk.sv ----
// Assertions on the command link between controller and die and on the bench's second link.
// Assumes one clock and the shortened counts used by the bench.
`timescale 1ns/1ps
`default_nettype none
module pprr_chk
  import pprr_pkg::*;
#(
  parameter int unsigned PGM_CYC    = FUSE_PGM_CYC,
  parameter logic [7:0]  AVAIL_CODE = 8'h01  // Arbitrary capability code
) (
  input wire logic         clk,
  input wire logic         arst_n,
  input wire pprr_cmd_type cmd,
  input wire logic         cmd_valid,
  input wire logic [7:0]   mr_addr,
  input wire logic [7:0]   mr_data,
  input wire logic [7:0]   rd_data,
  input wire logic         rd_valid,
  input wire logic         ready,
  input wire pprr_cmd_type cmd_b,
  input wire logic         cmd_valid_b,
  input wire logic [7:0]   mr_addr_b,
  input wire logic [7:0]   rd_data_b,
  input wire logic         rd_valid_b,
  input wire logic         ready_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic        tk;
  logic        rd_req;
  logic        mode_r;
  logic [31:0] age_r;
  logic        tk_b;
  logic        rd_req_b;
  assign tk = cmd_valid && ready;
  assign rd_req = tk && cmd == PPRR_CMD_MRR;
  // Second link carries the bench's mode reads
  assign tk_b = cmd_valid_b && ready_b;
  assign rd_req_b = tk_b && cmd_b == PPRR_CMD_MRR;
  // Age since last activate, repair mode bit as written
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_r  <= 32'h0;
      mode_r <= 1'b0;
    end else begin
      age_r <= (tk && cmd == PPRR_CMD_ACT) ? 32'h0 : age_r + 32'h1;
      if (tk && cmd == PPRR_CMD_MRW && mr_addr == REFRESH_REPAIR_MODE_REG)
        mode_r <= mr_data[REPAIR_ENABLE_BIT];
    end
  end
  a_act_in_mode: assert property (
    tk && cmd == PPRR_CMD_ACT |-> mode_r) else $error("act outside mode");
  a_enter_gap: assert property (
    tk && cmd == PPRR_CMD_MRW && mr_data[4] |=> !tk [*2])
    else $error("command inside mode write delay");
  a_pgm_quiet: assert property (
    tk && cmd == PPRR_CMD_ACT |=> !ready [*8]) else $error("ready in pgm");
  a_pgm_time: assert property (
    tk && cmd == PPRR_CMD_PRE |-> age_r + 32'h1 >= PGM_CYC)
    else $error("precharge too early");
  a_latch_gap: assert property (
    tk && cmd == PPRR_CMD_PRE |=> !tk) else $error("command in latch");
  a_settle_quiet: assert property (
    tk && cmd == PPRR_CMD_MRW && mr_addr == REFRESH_REPAIR_MODE_REG
    && !mr_data[4] |=> !ready [*8]) else $error("ready in settle");
  a_rd_cause: assert property (
    rd_valid |-> $past(rd_req)) else $error("read answer without read");
  a_avail_code: assert property (
    rd_req_b && mr_addr_b == REPAIR_AVAILABILITY_REG
    |=> rd_data_b == AVAIL_CODE)
    else $error("wrong capability code");
  a_rd_answer: assert property (
    rd_req_b |=> rd_valid_b) else $error("read not answered");
  a_rd_hold: assert property (
    !rd_valid |-> $stable(rd_data)) else $error("read data moved");
  // Main scenarios seen on both links
  c_act: cover property (tk && cmd == PPRR_CMD_ACT);
  c_pre: cover property (tk && cmd == PPRR_CMD_PRE);
  c_exit: cover property (tk && cmd == PPRR_CMD_MRW && !mr_data[4]);
  c_avail: cover property (rd_req_b && mr_addr_b == REPAIR_AVAILABILITY_REG);
endmodule
`default_nettype wire

// ---- post_package_row_repair_tb_top.sv ----
// Bench: controller and die joined by a link, a second die driven here.
// Assumes shortened programming and settle counts on all ends.
`timescale 1ns/1ps
`default_nettype none
module post_package_row_repair_tb_top;
  import pprr_pkg::*;
  localparam int unsigned PGM = 20;
  localparam int unsigned STL = 8;
  logic clk, arst_n, req, arm, idle, busy, done, nrst, lost, err, err2;
  logic [BANK_W-1:0] rb;
  logic [ROW_W-1:0] rr;
  logic [BANKS-1:0] fu, fu2, mused;
  logic [BANKS*ROW_W-1:0] fr, fr2;
  logic [ROW_W-1:0] mrow [BANKS];
  logic [31:0] rv;
  int fail_count, checks_done, seed, i, k;
  pprr_if lnk ();
  pprr_if lnk2 ();
  pprr_ctrl #(.PGM_CYC(PGM), .SETTLE(STL)) pprr_ctrl_i (.clk(clk),
    .arst_n(arst_n), .lnk(lnk.ctrl), .req(req), .arm(arm),
    .banks_idle(idle), .req_bank(rb), .req_row(rr), .busy(busy),
    .done(done), .need_reset(nrst));
  pprr_die #(.PGM_CYC(PGM), .SETTLE(STL)) pprr_die_i (.clk(clk),
    .arst_n(arst_n), .lnk(lnk.die), .fuse_used(fu), .fuse_rows(fr),
    .repair_busy(), .contents_lost(lost), .repair_error(err));
  pprr_die #(.PGM_CYC(PGM), .SETTLE(STL)) pprr_die_i2 (.clk(clk),
    .arst_n(arst_n), .lnk(lnk2.die), .fuse_used(fu2), .fuse_rows(fr2),
    .repair_busy(), .contents_lost(), .repair_error(err2));
  pprr_chk #(.PGM_CYC(PGM)) pprr_chk_i (.clk(clk), .arst_n(arst_n),
    .cmd(lnk.cmd), .cmd_valid(lnk.cmd_valid), .mr_addr(lnk.mr_addr),
    .mr_data(lnk.mr_data), .rd_data(lnk.rd_data),
    .rd_valid(lnk.rd_valid), .ready(lnk.ready), .cmd_b(lnk2.cmd),
    .cmd_valid_b(lnk2.cmd_valid), .mr_addr_b(lnk2.mr_addr),
    .rd_data_b(lnk2.rd_data), .rd_valid_b(lnk2.rd_valid),
    .ready_b(lnk2.ready));
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [ROW_W-1:0] exp_row(input int b);
    return mused[b] ? mrow[b] : '0;
  endfunction
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    mused = '0;
  endtask
  // One full repair through the controller, then settle
  task automatic repair(input logic [2:0] b, input logic [13:0] r);
    rb = b;
    rr = r;
    req = 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
      if (busy === 1'b1) req = 1'b0;
    end
    req = 1'b0;
    chk_flag(done, 1'b1);
    mused[b] = 1'b1;
    mrow[b] = r;
    chk_val(fu, mused);
    chk_val(fr[b*ROW_W +: ROW_W], exp_row(b));
    repeat (STL + 2) @(negedge clk);
  endtask
  // Bench command on the second link, held until taken
  task automatic put(input pprr_cmd_type c, input logic [7:0] a,
                     input logic [7:0] d, input logic [13:0] r);
    lnk2.cmd = c;
    lnk2.mr_addr = a;
    lnk2.mr_data = d;
    lnk2.row = r;
    lnk2.cmd_valid = 1'b1;
    k = 0;
    // Ready moves only at posedge, so its value here holds at the next one
    while (lnk2.ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) fail_count++;
    @(negedge clk);
    lnk2.cmd_valid = 1'b0;
    lnk2.cmd = PPRR_CMD_NOP;
    lnk2.row = ~r;
    @(negedge clk);
  endtask
  // enter, fuse bank 2, exit; optional refresh in programming
  task automatic seq2(input logic [13:0] r, input logic bad);
    put(PPRR_CMD_MRW, REFRESH_REPAIR_MODE_REG, 8'h10, r);
    repeat (MODE_WR_CYC) @(negedge clk);
    put(PPRR_CMD_ACT, 8'h00, 8'h00, r);
    if (bad) begin
      lnk2.cmd = PPRR_CMD_REF;
      lnk2.cmd_valid = 1'b1;
      @(negedge clk);
      lnk2.cmd_valid = 1'b0;
      chk_flag(err2, 1'b1);
      @(negedge clk);
    end
    put(PPRR_CMD_PRE, 8'h00, 8'h00, r);
    repeat (LATCH_CYC + 1) @(negedge clk);
    put(PPRR_CMD_MRW, REFRESH_REPAIR_MODE_REG, 8'h00, r);
    repeat (STL + 1) @(negedge clk);
    chk_flag(fu2[2], 1'b1);
    chk_val(fr2[2*ROW_W +: ROW_W], 32'h1234);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 6000);
    fail_count++;
    final_report();
  end
  initial begin
    seed = 60;
    {req, arm, idle, rb, rr} = {3'b011, 17'h0};
    lnk2.cmd = PPRR_CMD_NOP;
    {lnk2.cmd_valid, lnk2.bank, lnk2.row} = {1'b0, 3'h2, 14'h0};
    {lnk2.mr_addr, lnk2.mr_data} = 16'h0;
    do_reset();
    // start refused without arm or with open banks
    for (i = 0; i < 2; i++) begin
      arm = i[0];
      idle = !i[0];
      req = 1'b1;
      repeat (10) @(negedge clk);
      chk_flag(busy, 1'b0);
      req = 1'b0;
      chk_val(fu, mused);
      @(negedge clk);
    end
    {arm, idle} = 2'b11;
    rv = $random(seed);
    for (i = 0; i < 8; i++) begin
      rv = $random(seed);
      if (i == 0) rv = 32'h0;
      if (i == 7) rv = 32'h3fff;
      repair(3'((i * 3 + 5) % 8), rv[13:0]);
    end
    chk_flag(nrst, 1'b1);
    chk_flag(lost, 1'b1);
    chk_flag(err, 1'b0);
    do_reset();
    chk_flag(nrst, 1'b0);
    repair(3'h4, 14'h2a5a);
    put(PPRR_CMD_MRW, REPAIR_AVAILABILITY_REG, 8'hff, 14'h0);
    put(PPRR_CMD_MRR, REPAIR_AVAILABILITY_REG, 8'h00, 14'h0);
    @(negedge clk);
    chk_val(lnk2.rd_data, 32'h01);
    put(PPRR_CMD_ACT, 8'h00, 8'h00, 14'h0055);
    put(PPRR_CMD_PRE, 8'h00, 8'h00, 14'h0055);
    chk_val(fu2, 32'h0);
    seq2(14'h1234, 1'b1);
    seq2(14'h0abc, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
